// File: port_pin_regs.svh
`ifndef PORT_PIN_REGS_SVH
`define PORT_PIN_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PIN01_SELECT_ADDR     9'h081
`define PIN23_SELECT_ADDR     9'h082
`define POLARITY_DRIVE_ADDR   9'h083
`define RUN_LEVEL_LOW_ADDR    9'h084
`define RUN_LEVEL_HIGH_ADDR   9'h085

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PIN01_SELECT_RESET    8'h50
`define PIN23_SELECT_RESET    8'h12
`define POLARITY_DRIVE_RESET  8'h00
`define RUN_LEVEL_LOW_RESET   8'hff
`define RUN_LEVEL_HIGH_RESET  8'hff
`define READ_DATA_RESET       8'h00
`define UNMAPPED_READ_DATA    8'h00
`define PIN_RESET             1'b0
`define DRIVE_EN_RESET        4'h0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SELECT_EVEN_MSB       3
`define SELECT_EVEN_LSB       0
`define SELECT_ODD_MSB        7
`define SELECT_ODD_LSB        4
`define INVERT_MSB            3
`define INVERT_LSB            0
`define DRIVE_MSB             7
`define DRIVE_LSB             4
`define RUN_EVEN_CFG_A_BIT    0
`define RUN_EVEN_CFG_B_BIT    1
`define RUN_ODD_CFG_A_BIT     4
`define RUN_ODD_CFG_B_BIT     5

`endif

// File: port_pin_pkg.sv
package port_pin_pkg;

	typedef enum logic [3:0] {
		src_clock_out    = 4'h0,
		src_run          = 4'h1,
		src_irq          = 4'h2,
		src_low          = 4'h3,
		src_high         = 4'h4,
		src_data         = 4'h5,
		src_filter_data  = 4'h6,
		src_chip_data    = 4'h8,
		src_chip_strobe  = 4'h9,
		src_rx_data      = 4'ha,
		src_rx_strobe    = 4'hb
	} pin_source_type;

	typedef struct packed {
		logic clock_out;
		logic rx_running;
		logic interrupt_request_n;
		logic data;
		logic matched_filter_data;
		logic chip_data;
		logic chip_strobe;
		logic received_data;
		logic receive_strobe;
	} source_signals_type;

	typedef struct packed {
		logic       write;
		logic [8:0] address;
		logic [7:0] write_data;
	} reg_request_type;

endpackage : port_pin_pkg

// File: pin_output_mux.sv
`timescale 1ns/1ns

module pin_output_mux #(
	parameter bit HAS_CLOCK_OUT = 1'b1
) (
	input  wire logic                             config_b_active,
	input  wire port_pin_pkg::source_signals_type sources,
	input  wire logic [3:0]                       select,
	input  wire logic                             invert,
	input  wire logic                             run_level_cfg_a,
	input  wire logic                             run_level_cfg_b,
	output logic                                  pin_value
);
	import port_pin_pkg::*;

	logic run_level;
	logic run_indicator;
	logic selected;

	always_comb begin
		// polarity follows whichever configuration is live
		run_level     = config_b_active ? run_level_cfg_b : run_level_cfg_a;
		run_indicator = run_level ? sources.rx_running : ~sources.rx_running;
		case (select)
			src_clock_out:   selected = HAS_CLOCK_OUT ? sources.clock_out : 1'b0;
			src_run:         selected = run_indicator;
			src_irq:         selected = sources.interrupt_request_n;
			src_low:         selected = 1'b0;
			src_high:        selected = 1'b1;
			src_data:        selected = sources.data;
			src_filter_data: selected = sources.matched_filter_data;
			src_chip_data:   selected = sources.chip_data;
			src_chip_strobe: selected = sources.chip_strobe;
			src_rx_data:     selected = sources.received_data;
			src_rx_strobe:   selected = sources.receive_strobe;
			// unused codes select a constant 0, so the pin sits at its invert bit and never floats to a stale value
			default:         selected = 1'b0;
		endcase
		pin_value = selected ^ invert;
	end

endmodule : pin_output_mux

// File: port_pin_output_select.sv
// What this block does
// - Pin three's 4-bit selector picks run indicator, interrupt, low, high, data, filter data, chip data/strobe, rx data/strobe, resets to 1.
// - Pin two's selector uses the same table with 0000 giving the divided clock, resets to 2.
// - Under configuration A pin zero's run indicator is active high when its level bit is 1, else active low; bit resets to 1.
// - Under configuration B pin zero's run indicator takes polarity from its own bit, resetting to 1.
// - Under configuration A pin one's run indicator polarity follows its own level bit, resetting to 1.
// - Under configuration B pin one's run indicator polarity follows its own level bit, resetting to 1.
// - Under configuration A pin two's run indicator polarity follows its own level bit, resetting to 1.
// - Under configuration B pin two's run indicator polarity follows its own level bit, resetting to 1.
// - Under configuration A pin three's run indicator polarity follows its own level bit, resetting to 1.
// - Under configuration B pin three's run indicator polarity follows its own level bit, resetting to 1.
// - Pins zero and one have selectors with the same table, 0000 the divided clock, resetting to 0000 and 0101.
`timescale 1ns/1ns
`include "port_pin_regs.svh"

module port_pin_output_select (
	input  wire logic                             clock,
	input  wire logic                             arst_n,
	input  wire port_pin_pkg::reg_request_type    reg_request,
	output logic [7:0]                            reg_read_data,
	input  wire logic                             config_b_active,
	input  wire port_pin_pkg::source_signals_type sources,
	output logic                                  port_pin_zero,
	output logic                                  port_pin_one,
	output logic                                  port_pin_two,
	output logic                                  port_pin_three,
	output logic [3:0]                            high_drive_en
);
	import port_pin_pkg::*;

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	logic [7:0] pin01_signal_select;
	logic [7:0] pin2_pin3_signal_select;
	logic [7:0] pin_polarity_drive_cfg;
	logic [7:0] run_level_cfg_low_pins;
	logic [7:0] run_level_cfg_high_pins;
	logic [7:0] next_pin01_signal_select;
	logic [7:0] next_pin2_pin3_signal_select;
	logic [7:0] next_pin_polarity_drive_cfg;
	logic [7:0] next_run_level_cfg_low_pins;
	logic [7:0] next_run_level_cfg_high_pins;
	logic [7:0] next_reg_read_data;

	always_comb begin
		next_pin01_signal_select     = pin01_signal_select;
		next_pin2_pin3_signal_select = pin2_pin3_signal_select;
		next_pin_polarity_drive_cfg  = pin_polarity_drive_cfg;
		next_run_level_cfg_low_pins  = run_level_cfg_low_pins;
		next_run_level_cfg_high_pins = run_level_cfg_high_pins;
		if (reg_request.write) begin
			case (reg_request.address)
				`PIN01_SELECT_ADDR:   next_pin01_signal_select     = reg_request.write_data;
				`PIN23_SELECT_ADDR:   next_pin2_pin3_signal_select = reg_request.write_data;
				`POLARITY_DRIVE_ADDR: next_pin_polarity_drive_cfg  = reg_request.write_data;
				`RUN_LEVEL_LOW_ADDR:  next_run_level_cfg_low_pins  = reg_request.write_data;
				`RUN_LEVEL_HIGH_ADDR: next_run_level_cfg_high_pins = reg_request.write_data;
				default: begin
				end
			endcase
		end
		// readback mirrors the stored byte; unmapped addresses read zero
		case (reg_request.address)
			`PIN01_SELECT_ADDR:   next_reg_read_data = pin01_signal_select;
			`PIN23_SELECT_ADDR:   next_reg_read_data = pin2_pin3_signal_select;
			`POLARITY_DRIVE_ADDR: next_reg_read_data = pin_polarity_drive_cfg;
			`RUN_LEVEL_LOW_ADDR:  next_reg_read_data = run_level_cfg_low_pins;
			`RUN_LEVEL_HIGH_ADDR: next_reg_read_data = run_level_cfg_high_pins;
			default:              next_reg_read_data = `UNMAPPED_READ_DATA;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pin01_signal_select     <= `PIN01_SELECT_RESET;
			pin2_pin3_signal_select <= `PIN23_SELECT_RESET;
			pin_polarity_drive_cfg  <= `POLARITY_DRIVE_RESET;
			run_level_cfg_low_pins  <= `RUN_LEVEL_LOW_RESET;
			run_level_cfg_high_pins <= `RUN_LEVEL_HIGH_RESET;
			reg_read_data           <= `READ_DATA_RESET;
		end else begin
			pin01_signal_select     <= next_pin01_signal_select;
			pin2_pin3_signal_select <= next_pin2_pin3_signal_select;
			pin_polarity_drive_cfg  <= next_pin_polarity_drive_cfg;
			run_level_cfg_low_pins  <= next_run_level_cfg_low_pins;
			run_level_cfg_high_pins <= next_run_level_cfg_high_pins;
			reg_read_data           <= next_reg_read_data;
		end
	end

	// ---------------------------------------------------------------
	// per-pin selection
	// ---------------------------------------------------------------
	logic [3:0] pin_value;
	logic [3:0] invert_bits;

	assign invert_bits = pin_polarity_drive_cfg[`INVERT_MSB:`INVERT_LSB];

	pin_output_mux #(.HAS_CLOCK_OUT(1'b1)) pin0_mux (
		.config_b_active (config_b_active),
		.sources         (sources),
		.select          (pin01_signal_select[`SELECT_EVEN_MSB:`SELECT_EVEN_LSB]),
		.invert          (invert_bits[0]),
		.run_level_cfg_a (run_level_cfg_low_pins[`RUN_EVEN_CFG_A_BIT]),
		.run_level_cfg_b (run_level_cfg_low_pins[`RUN_EVEN_CFG_B_BIT]),
		.pin_value       (pin_value[0])
	);

	pin_output_mux #(.HAS_CLOCK_OUT(1'b1)) pin1_mux (
		.config_b_active (config_b_active),
		.sources         (sources),
		.select          (pin01_signal_select[`SELECT_ODD_MSB:`SELECT_ODD_LSB]),
		.invert          (invert_bits[1]),
		.run_level_cfg_a (run_level_cfg_low_pins[`RUN_ODD_CFG_A_BIT]),
		.run_level_cfg_b (run_level_cfg_low_pins[`RUN_ODD_CFG_B_BIT]),
		.pin_value       (pin_value[1])
	);

	pin_output_mux #(.HAS_CLOCK_OUT(1'b1)) pin2_mux (
		.config_b_active (config_b_active),
		.sources         (sources),
		.select          (pin2_pin3_signal_select[`SELECT_EVEN_MSB:`SELECT_EVEN_LSB]),
		.invert          (invert_bits[2]),
		.run_level_cfg_a (run_level_cfg_high_pins[`RUN_EVEN_CFG_A_BIT]),
		.run_level_cfg_b (run_level_cfg_high_pins[`RUN_EVEN_CFG_B_BIT]),
		.pin_value       (pin_value[2])
	);

	// pin three has no divided clock: its code 0000 is unused and parks at its invert bit
	pin_output_mux #(.HAS_CLOCK_OUT(1'b0)) pin3_mux (
		.config_b_active (config_b_active),
		.sources         (sources),
		.select          (pin2_pin3_signal_select[`SELECT_ODD_MSB:`SELECT_ODD_LSB]),
		.invert          (invert_bits[3]),
		.run_level_cfg_a (run_level_cfg_high_pins[`RUN_ODD_CFG_A_BIT]),
		.run_level_cfg_b (run_level_cfg_high_pins[`RUN_ODD_CFG_B_BIT]),
		.pin_value       (pin_value[3])
	);

	// ---------------------------------------------------------------
	// output registers
	// ---------------------------------------------------------------
	// pins are registered so the host never sees mux glitches; costs one cycle of latency
	logic [3:0] next_pins;
	logic [3:0] next_high_drive_en;

	always_comb begin
		next_pins          = pin_value;
		next_high_drive_en = pin_polarity_drive_cfg[`DRIVE_MSB:`DRIVE_LSB];
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			port_pin_zero  <= `PIN_RESET;
			port_pin_one   <= `PIN_RESET;
			port_pin_two   <= `PIN_RESET;
			port_pin_three <= `PIN_RESET;
			high_drive_en  <= `DRIVE_EN_RESET;
		end else begin
			port_pin_zero  <= next_pins[0];
			port_pin_one   <= next_pins[1];
			port_pin_two   <= next_pins[2];
			port_pin_three <= next_pins[3];
			high_drive_en  <= next_high_drive_en;
		end
	end

endmodule : port_pin_output_select

// File: port_pin_host_model.sv
`timescale 1ns/1ns
module port_pin_host_model (
	input  wire logic       clock,
	input  wire logic [3:0] pins,
	output logic [3:0]      sampled
);
	// the host latches its port on the rising edge, so it sees pins one edge late
	always_ff @(posedge clock) begin
		sampled <= pins;
	end
endmodule : port_pin_host_model

// File: port_pin_output_select_props.sv
`timescale 1ns/1ns
module port_pin_output_select_props (
	input wire logic                             clock,
	input wire logic                             arst_n,
	input wire port_pin_pkg::reg_request_type    reg_request,
	input wire logic [7:0]                       reg_read_data,
	input wire logic                             config_b_active,
	input wire port_pin_pkg::source_signals_type sources,
	input wire logic                             port_pin_zero,
	input wire logic                             port_pin_one,
	input wire logic                             port_pin_two,
	input wire logic                             port_pin_three,
	input wire logic [3:0]                       high_drive_en
);
	import port_pin_pkg::*;
	// ----
	// shadow registers
	// ----
	logic [7:0] sel, pol, lvl;
	wire logic run2 = sources.rx_running ^ ~(config_b_active ? lvl[1] : lvl[0]);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{sel, pol, lvl} <= 24'h1200ff;
		end else if (reg_request.write && reg_request.address == 9'h082) begin
			sel <= reg_request.write_data;
		end else if (reg_request.write && reg_request.address == 9'h083) begin
			pol <= reg_request.write_data;
		end else if (reg_request.write && reg_request.address == 9'h085) begin
			lvl <= reg_request.write_data;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_wr(a); reg_request.write && reg_request.address == a; endsequence
	sequence s_rd(a); !reg_request.write && reg_request.address == a; endsequence
	a_drive_follows_write: assert property (s_wr(9'h083) |-> ##2 high_drive_en == $past(reg_request.write_data[7:4], 2))
		else $error("drive enables differ from write");
	a_unmapped_reads_zero: assert property ((reg_request.address < 9'h081 || reg_request.address > 9'h085) |=> reg_read_data == 8'h00)
		else $error("unmapped read not zero");
	a_polarity_read_back: assert property (s_rd(9'h083) |=> reg_read_data == $past(pol))
		else $error("polarity readback wrong");
	a_level_read_back: assert property (s_rd(9'h085) |=> reg_read_data == $past(lvl))
		else $error("run level readback wrong");
	a_pin2_const_low: assert property (sel[3:0] == 4'h3 |=> port_pin_two == $past(pol[2]))
		else $error("pin two low code wrong");
	a_pin3_const_high: assert property (sel[7:4] == 4'h4 |=> port_pin_three == !$past(pol[3]))
		else $error("pin three high code wrong");
	a_pin3_irq_route: assert property (sel[7:4] == 4'h2 |=> port_pin_three == ($past(sources.interrupt_request_n) ^ $past(pol[3])))
		else $error("pin three interrupt route wrong");
	a_pin2_run_level: assert property (sel[3:0] == 4'h1 |=> port_pin_two == ($past(run2) ^ $past(pol[2])))
		else $error("pin two run level wrong");
	a_pin2_clock_route: assert property (sel[3:0] == 4'h0 |=> port_pin_two == ($past(sources.clock_out) ^ $past(pol[2])))
		else $error("pin two clock route wrong");
	a_pin3_unused_code: assert property (sel[7:4] == 4'h0 |=> port_pin_three == $past(pol[3]))
		else $error("pin three unused code wrong");
endmodule : port_pin_output_select_props

bind port_pin_output_select port_pin_output_select_props props (.clock, .arst_n, .reg_request, .reg_read_data,
	.config_b_active, .sources, .port_pin_zero, .port_pin_one, .port_pin_two, .port_pin_three, .high_drive_en);

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import port_pin_pkg::*;
	logic               clock, arst_n, config_b_active;
	reg_request_type    reg_request;
	source_signals_type sources;
	logic [7:0]         reg_read_data, r84, r85, pol;
	logic [3:0]         high_drive_en, sampled, c;
	wire logic [3:0]    pins;
	logic [8:0]         notes[$], note;
	logic [7:0]         rst_tab[7] = '{8'h00, 8'h50, 8'h12, 8'h00, 8'hff, 8'hff, 8'h00};
	int                 n_errors, n_checks, cycles;
	event               ev;
	port_pin_output_select dut (.clock(clock), .arst_n(arst_n), .reg_request(reg_request),
		.reg_read_data(reg_read_data), .config_b_active(config_b_active), .sources(sources),
		.port_pin_zero(pins[0]), .port_pin_one(pins[1]), .port_pin_two(pins[2]), .port_pin_three(pins[3]),
		.high_drive_en(high_drive_en));
	port_pin_host_model host (.clock(clock), .pins(pins), .sampled(sampled));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic cyc;
		@(posedge clock);
		#2;
	endtask : cyc
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		cyc();
		reg_request = '{1'b1, a, d};
		cyc();
		reg_request.write = 1'b0;
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [7:0] d);
		cyc();
		reg_request = '{1'b0, a, 8'h00};
		cyc();
		notes.push_back({1'b1, d});
		->ev;
	endtask : rd
	function automatic logic pin_exp(input int i, input logic [3:0] code);
		logic lvl, v;
		lvl = 1'((i < 2 ? r84 : r85) >> ((i % 2) * 4 + int'(config_b_active)));
		case (code)
			4'h0: v = (i < 3) & sources.clock_out;
			4'h1: v = sources.rx_running ^ ~lvl;
			4'h2: v = sources.interrupt_request_n;
			4'h4: v = 1'b1;
			4'h5: v = sources.data;
			4'h6: v = sources.matched_filter_data;
			4'h8: v = sources.chip_data;
			4'h9: v = sources.chip_strobe;
			4'ha: v = sources.received_data;
			4'hb: v = sources.receive_strobe;
			default: v = 1'b0;
		endcase
		return v ^ pol[i];
	endfunction : pin_exp
	// pins reach the host latch two edges after the last write
	task automatic expect_pins(input logic [3:0] c0, c1, c2, c3);
		repeat (3) cyc();
		notes.push_back({1'b0, pin_exp(3, c3), pin_exp(2, c2), pin_exp(1, c1), pin_exp(0, c0), pol[7:4]});
		->ev;
	endtask : expect_pins
	initial begin
		forever begin
			@(ev);
			note = notes.pop_front();
			if (note[8]) check(reg_read_data, note[7:0]);
			else check({sampled, high_drive_en}, note[7:0]);
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(32'h72c830e7));
		{arst_n, config_b_active, reg_request, sources} = '0;
		repeat (10) @(posedge clock);
		#2 arst_n = 1'b1;
		for (int k = 0; k < 7; k++) rd(9'h080 + 9'(k), rst_tab[k]);
		{r84, r85, pol} = 24'hffff00;
		sources = 9'($urandom);
		expect_pins(4'h0, 4'h5, 4'h2, 4'h1);
		for (int n = 0; n < 64; n++) begin
			c = 4'(n);
			{r84, r85, pol} = 24'($urandom);
			wr(9'h081, {c, c});
			wr(9'h082, {c, c});
			wr(9'h083, pol);
			wr(9'h084, r84);
			wr(9'h085, r85);
			wr(9'h086, 8'($urandom));
			sources = 9'($urandom);
			config_b_active = 1'($urandom);
			expect_pins(c, c, c, c);
			rd(9'h082, {c, c});
			rd(9'h084, r84);
		end
		cyc();
		arst_n = 1'b0;
		cyc();
		arst_n = 1'b1;
		rd(9'h082, 8'h12);
		rd(9'h083, 8'h00);
		// a mid-run reset must bring the pins back to their reset selections
		{r84, r85, pol} = 24'hffff00;
		expect_pins(4'h0, 4'h5, 4'h2, 4'h1);
		// let the watcher take the last note before the run ends
		cyc();
		conclude();
	end
endmodule : tb_top
